// ### bench/ssr_mcu_model.sv
// microcontroller side model: pull-ups on the four reset lines, hold-on drive
// assumes the supervisor gives a drive value and an enable for each reset line
`timescale 1ns/100ps
module ssr_mcu_model (
  input  wire logic       i_hold_cmd,  // bench asks firmware to hold regulators on
  input  wire logic [3:0] i_reset_oe,  // {kam,main,io,core} pull enables
  input  wire logic [3:0] i_reset_drv, // drive values, only meaningful when enabled
  output logic      [3:0] o_reset_pin, // resolved line levels
  output logic            o_hold_on    // regulator hold-on level
);
  // ---------------------------------------------------------------
  // reset lines
  // ---------------------------------------------------------------
  // a released line goes to the pull-up level, never to the last driven value
  assign o_reset_pin = (i_reset_oe & i_reset_drv) | ~i_reset_oe;
  // ---------------------------------------------------------------
  // hold-on output
  // ---------------------------------------------------------------
  // firmware may keep regulators on after ignition drops; bench changes it on an edge
  assign o_hold_on = i_hold_cmd;
endmodule : ssr_mcu_model

// ### bench/ssr_supervisor_test.sv
// self-checking bench for the supply reset supervisor
// assumes shortened timer parameters: 20-cycle delay step, 16-cycle strap capture
`timescale 1ns/100ps
module ssr_supervisor_test;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int STEP = 20;  // cycles per delay code step
  logic        clk;          // 20 MHz core clock
  logic        arst_n;       // active-low reset
  logic        ign;          // ignition level
  logic        hold_cmd;     // request to the firmware model
  logic        input_undervoltage_lockout;         // input lockout level
  logic [2:0]  strap;        // {a,b,c}
  logic [4:0]  flt;          // core_low,io_low,main_low,main_high,kam_low
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;           // bus byte enables
  wire         hold;
  wire  [3:0]  pin;          // {kam,main,io,core}
  wire  [3:0]  oe;
  wire  [3:0]  drv;
  wire  [3:0]  en;
  wire  [1:0]  pd;           // {io,core}
  wire  [31:0] rdata;
  wire         wreq;
  int          n_errors;
  int          check_count;
  int          mon[5] = '{0, 1, 2, 2, 3};  // fault index to reset line
  // expected voltage words by strap pattern {a,b,c}: {core,io,kam}
  logic [31:0] vsel_tab[8] = '{32'h159, 32'h158, 32'h116, 32'h168, 32'h168, 32'h068, 32'h16D, 32'h0EB};
  ssr_mcu_model i_mcu (.i_hold_cmd(hold_cmd), .i_reset_oe(oe), .i_reset_drv(drv), .o_reset_pin(pin),
    .o_hold_on(hold));
  ssr_supervisor #(.P_STEP_CYC(STEP), .P_STRAP_CYC(16)) i_dut (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_ignition_in(ign), .i_regulator_hold_on(hold),
    .i_volt_strap_a(strap[2]), .i_volt_strap_b(strap[1]), .i_volt_strap_c(strap[0]),
    .i_input_undervoltage_lockout(input_undervoltage_lockout), .i_core_supply_low(flt[0]), .i_io_supply_low(flt[1]),
    .i_main_supply_low(flt[2]), .i_main_supply_high(flt[3]), .i_keepalive_supply_low(flt[4]),
    .i_core_supply_reset_n(pin[0]), .i_io_supply_reset_n(pin[1]), .i_main_supply_reset_n(pin[2]),
    .i_keepalive_reset_n(pin[3]), .o_core_supply_reset_n(drv[0]), .o_io_supply_reset_n(drv[1]),
    .o_main_supply_reset_n(drv[2]), .o_keepalive_reset_n(drv[3]), .o_core_supply_reset_oe(oe[0]),
    .o_io_supply_reset_oe(oe[1]), .o_main_supply_reset_oe(oe[2]), .o_keepalive_reset_oe(oe[3]),
    .o_core_supply_en(en[0]), .o_io_supply_en(en[1]), .o_main_supply_en(en[2]),
    .o_keepalive_supply_en(en[3]), .o_core_pulldown(pd[0]), .o_io_pulldown(pd[1]),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));
  always #25 clk = ~clk;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  // cycle counts are bench values, so a plain range check suffices
  task automatic chk_range(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_range
  // one avalon transfer; request held until waitrequest is sampled low, a hang is left to the watchdog
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk_range("bus answer", 2, 2, n);
  endtask : bus
  // bounded wait for one reset enable to reach a level, counted in edges
  task automatic wait_oe(input int k, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (oe[k] !== v && n < lim);
  endtask : wait_oe
  task automatic all_free();
    int n;
    for (int k = 0; k < 4; k++) wait_oe(k, 1'b0, 80, n);
    chk_word("pins free", 32'hF, {28'h0, pin});
  endtask : all_free
  task automatic do_reset(input logic [2:0] s);
    @(posedge clk);
    arst_n <= 1'b0;
    strap <= s;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (24) @(posedge clk);
  endtask : do_reset
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // every strap pattern from reset, checked in sleep; then latch holds
  task automatic t_straps();
    logic [31:0] q;
    logic        sb;
    for (int p = 0; p < 8; p++) begin
      sb = (p == 0 || p == 1 || p == 3);
      do_reset(p[2:0]);
      bus(1'b0, ssr_pkg::ADDR_VSEL, 32'h0, q);
      chk_word("vsel", vsel_tab[p], q);
      bus(1'b0, ssr_pkg::ADDR_STATUS, 32'h0, q);
      chk_word("status", {16'h0, sb, 2'b11, p[2:0], 2'b01, 8'hFF}, q);
      chk_bit("io_en", sb, en[1]);
      chk_bit("kam_en", 1'b1, en[3]);
      chk_bit("core_en", 1'b0, en[0]);
      chk_bit("io pulldown", !sb, pd[1]);
      chk_bit("core pulldown", 1'b1, pd[0]);
      chk_word("oe", 32'h0, {28'h0, oe});
    end
    strap <= 3'b000;
    repeat (20) @(posedge clk);
    bus(1'b0, ssr_pkg::ADDR_VSEL, 32'h0, q);
    chk_word("vsel held", vsel_tab[7], q);
  endtask : t_straps
  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, ssr_pkg::ADDR_CTRL, 32'h0, q);
    chk_word("ctrl reset", 32'h0, q);
    bus(1'b1, ssr_pkg::ADDR_CTRL, 32'hFF, q);
    bus(1'b0, ssr_pkg::ADDR_CTRL, 32'h0, q);
    chk_word("ctrl", 32'h7, q);
    be <= 4'hE;
    bus(1'b1, ssr_pkg::ADDR_CTRL, 32'h5, q);
    be <= 4'hF;
    bus(1'b0, ssr_pkg::ADDR_CTRL, 32'h0, q);
    chk_word("ctrl masked", 32'h7, q);
    bus(1'b1, 4'hC, 32'hFFFFFFFF, q);
    bus(1'b0, 4'hC, 32'h0, q);
    chk_word("unmapped", 32'h0, q);
    bus(1'b1, ssr_pkg::ADDR_CTRL, 32'h0, q);
  endtask : t_regs
  // hold-on alone brings normal mode, ignition alone keeps it
  task automatic t_normal();
    hold_cmd <= 1'b1;
    repeat (8) @(posedge clk);
    chk_word("enables", 32'hF, {28'h0, en});
    chk_word("pulldowns", 32'h0, {30'h0, pd});
    all_free();
    ign <= 1'b1;
    hold_cmd <= 1'b0;
    repeat (8) @(posedge clk);
    chk_bit("core_en ign", 1'b1, en[0]);
  endtask : t_normal
  // glitch shorter than the filter, then a real fault, for each indication
  task automatic t_filter();
    int n;
    int n2;
    for (int k = 0; k < 5; k++) begin
      flt[k] <= 1'b1;
      wait_oe(mon[k], 1'b1, 300, n);
      flt[k] <= 1'b0;
      wait_oe(mon[k], 1'b1, 20, n2);
      chk_range("glitch", 320, 320, n + n2);
      flt[k] <= 1'b1;
      wait_oe(mon[k], 1'b1, 450, n);
      chk_range("filter", 400, 410, n);
      chk_bit("pin low", 1'b0, pin[mon[k]]);
      chk_bit("drive", 1'b0, drv[mon[k]]);
      flt[k] <= 1'b0;
      wait_oe(mon[k], 1'b0, 60, n);
      chk_range("release", 1, 8, n);
    end
  endtask : t_filter
  task automatic t_delay();
    logic [31:0] q;
    int          n;
    int          codes[3] = '{1, 7, 2};
    foreach (codes[i]) begin
      bus(1'b1, ssr_pkg::ADDR_CTRL, codes[i], q);
      flt[0] <= 1'b1;
      wait_oe(0, 1'b1, 450, n);
      flt[0] <= 1'b0;
      if (i == 2) begin
        // fault again in mid-release: the count starts over
        repeat (20) @(posedge clk);
        flt[0] <= 1'b1;
        repeat (30) @(posedge clk);
        flt[0] <= 1'b0;
      end
      wait_oe(0, 1'b0, 200, n);
      chk_range("delay", codes[i] * STEP, codes[i] * STEP + 8, n);
    end
    bus(1'b1, ssr_pkg::ADDR_CTRL, 32'h0, q);
  endtask : t_delay
  // sleep entry floats a held reset and drops the normal regulators
  task automatic t_sleep();
    int n;
    flt[0] <= 1'b1;
    wait_oe(0, 1'b1, 450, n);
    ign <= 1'b0;
    wait_oe(0, 1'b0, 10, n);
    chk_range("sleep float", 1, 8, n);
    repeat (3) @(posedge clk);
    chk_bit("core_en", 1'b0, en[0]);
    chk_bit("kam_en", 1'b1, en[3]);
    flt[0] <= 1'b0;
    ign <= 1'b1;
    // wake-up pulls the parked reset for one cycle at delay code zero
    wait_oe(0, 1'b1, 10, n);
    chk_range("wake hold", 5, 5, n);
    all_free();
  endtask : t_sleep
  task automatic t_hold();
    logic [31:0] q;
    hold_cmd <= 1'b1;
    repeat (8) @(posedge clk);
    ign <= 1'b0;
    repeat (20) @(posedge clk);
    chk_bit("held on", 1'b1, en[0]);
    hold_cmd <= 1'b0;
    repeat (8) @(posedge clk);
    chk_bit("shut down", 1'b0, en[0]);
    ign <= 1'b1;
    input_undervoltage_lockout <= 1'b1;
    repeat (8) @(posedge clk);
    chk_bit("lockout", 1'b0, en[2]);
    bus(1'b0, ssr_pkg::ADDR_STATUS, 32'h0, q);
    chk_bit("power down", 1'b1, q[14]);
    input_undervoltage_lockout <= 1'b0;
    repeat (8) @(posedge clk);
    all_free();
  endtask : t_hold
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // watchdog well beyond the roughly 6000 cycles the tests need
  initial begin
    #(50 * 40000);
    n_errors++;
    conclude();
  end
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    ign = 1'b0;
    hold_cmd = 1'b0;
    input_undervoltage_lockout = 1'b0;
    strap = 3'b000;
    flt = 5'h00;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    be = 4'hF;
    t_straps();
    t_regs();
    t_normal();
    t_filter();
    t_delay();
    t_sleep();
    t_hold();
    conclude();
  end
endmodule : ssr_supervisor_test

// ### hw/ssr_pkg.sv
// constants for the supply reset supervisor: timing, register map, codes
// assumes a 20 MHz core clock and an Avalon-MM slave with 32-bit data
package ssr_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned FILTER_US    = 20;
  localparam int unsigned STEP_MS      = 8;
  localparam int unsigned STRAP_US     = 500;
  // least times round up to whole cycles
  localparam int unsigned FILTER_CYC   = (FILTER_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned STEP_CYC     = STEP_MS * (CLK_HZ / 1000);
  localparam int unsigned STRAP_CYC    = (STRAP_US * (CLK_HZ / 1000) + 999) / 1000;
  // ---------------------------------------------------------------
  // register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h4;
  localparam logic [3:0]  ADDR_VSEL    = 4'h8;
  localparam logic [2:0]  CTRL_RESET   = 3'h0;
  // monitor index
  localparam int unsigned MON_CORE     = 0;
  localparam int unsigned MON_IO       = 1;
  localparam int unsigned MON_MAIN     = 2;
  localparam int unsigned MON_KAM      = 3;
  // ---------------------------------------------------------------
  // voltage selection codes
  // ---------------------------------------------------------------
  localparam logic [2:0]  V1P0         = 3'h0;
  localparam logic [2:0]  V1P5         = 3'h1;
  localparam logic [2:0]  V2P0         = 3'h2;
  localparam logic [2:0]  V2P6         = 3'h3;
  localparam logic [2:0]  V3P15        = 3'h4;
  localparam logic [2:0]  V3P3         = 3'h5;
  localparam logic [2:0]  V5P0         = 3'h6;
  // one-hot operating modes
  typedef enum logic [1:0] {
    MODE_SLEEP  = 2'b01,
    MODE_NORMAL = 2'b10
  } ssr_mode_t;
endpackage : ssr_pkg

// ### hw/ssr_supervisor.sv
// supply reset supervisor: glitch filter, release delay, mode, straps
// assumes all pin inputs are asynchronous and the bus runs on i_core_clk
`timescale 1ns/100ps
module ssr_supervisor #(
  parameter int unsigned P_STEP_CYC  = ssr_pkg::STEP_CYC,
  parameter int unsigned P_STRAP_CYC = ssr_pkg::STRAP_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  // control and strap pins
  input  wire logic        i_ignition_in,
  input  wire logic        i_regulator_hold_on,
  input  wire logic        i_volt_strap_a,
  input  wire logic        i_volt_strap_b,
  input  wire logic        i_volt_strap_c,
  input  wire logic        i_input_undervoltage_lockout,
  // supply regulation indications, high means out of window
  input  wire logic        i_core_supply_low,
  input  wire logic        i_io_supply_low,
  input  wire logic        i_main_supply_low,
  input  wire logic        i_main_supply_high,
  input  wire logic        i_keepalive_supply_low,
  // open-drain reset pins: level in, drive value, enable
  input  wire logic        i_core_supply_reset_n,
  input  wire logic        i_io_supply_reset_n,
  input  wire logic        i_main_supply_reset_n,
  input  wire logic        i_keepalive_reset_n,
  output logic             o_core_supply_reset_n,
  output logic             o_io_supply_reset_n,
  output logic             o_main_supply_reset_n,
  output logic             o_keepalive_reset_n,
  output logic             o_core_supply_reset_oe,
  output logic             o_io_supply_reset_oe,
  output logic             o_main_supply_reset_oe,
  output logic             o_keepalive_reset_oe,
  // regulator control
  output logic             o_core_supply_en,
  output logic             o_io_supply_en,
  output logic             o_main_supply_en,
  output logic             o_keepalive_supply_en,
  output logic             o_core_pulldown,
  output logic             o_io_pulldown,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);
  // ---------------------------------------------------------------
  // strap decode
  // ---------------------------------------------------------------
  // returns {io standby, core code, io code, keep-alive code}
  function automatic logic [9:0] ssr_decode(input logic [2:0] s);
    logic [9:0] r;
    r = 10'h000;
    case (s) // a,b,c
      3'b111: r = {1'b0, ssr_pkg::V2P6,  ssr_pkg::V3P3, ssr_pkg::V2P6};
      3'b110: r = {1'b0, ssr_pkg::V3P3,  ssr_pkg::V3P3, ssr_pkg::V3P3};
      3'b101: r = {1'b0, ssr_pkg::V1P5,  ssr_pkg::V3P3, ssr_pkg::V1P0};
      3'b100: r = {1'b0, ssr_pkg::V3P3,  ssr_pkg::V3P3, ssr_pkg::V1P0};
      3'b011: r = {1'b1, ssr_pkg::V3P3,  ssr_pkg::V3P3, ssr_pkg::V1P0};
      3'b010: r = {1'b0, ssr_pkg::V3P15, ssr_pkg::V2P0, ssr_pkg::V5P0};
      3'b001: r = {1'b1, ssr_pkg::V3P3,  ssr_pkg::V2P6, ssr_pkg::V1P0};
      default: r = {1'b1, ssr_pkg::V3P3, ssr_pkg::V2P6, ssr_pkg::V1P5};
    endcase
    return r;
  endfunction : ssr_decode

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [13:0]          sync1;        // first stage, read only by sync2
  logic [13:0]          sync2;        // safe copies of all pins
  logic                 ign;          // ignition, synced
  logic                 hold;         // regulator hold-on, synced
  logic [2:0]           strap_pin;    // live strap levels
  logic                 input_undervoltage_lockout;         // input lockout
  logic [3:0]           flt;          // per-monitor out-of-window
  logic [3:0]           pin_lvl;      // reset pin read-back

  // two flops on every pin; only sync2 looks at sync1
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1 <= 14'h0000;
      sync2 <= 14'h0000;
    end else begin
      sync1 <= {i_keepalive_reset_n, i_main_supply_reset_n, i_io_supply_reset_n,
                i_core_supply_reset_n, i_input_undervoltage_lockout, i_keepalive_supply_low,
                i_main_supply_low | i_main_supply_high, i_io_supply_low, i_core_supply_low,
                i_volt_strap_c, i_volt_strap_b, i_volt_strap_a,
                i_regulator_hold_on, i_ignition_in};
      sync2 <= sync1;
    end
  end

  // reset value 0 makes undriven control inputs look low
  assign ign       = sync2[0];
  assign hold      = sync2[1];
  assign strap_pin = {sync2[2], sync2[3], sync2[4]};
  assign flt       = sync2[8:5]; // main fault is low or high
  assign input_undervoltage_lockout      = sync2[9];
  assign pin_lvl   = sync2[13:10];

  // ---------------------------------------------------------------
  // strap latch
  // ---------------------------------------------------------------
  logic [31:0]          strap_cnt;    // cycles since reset release
  logic                 strap_done;   // straps captured
  logic [2:0]           strap_q;      // captured {a,b,c}
  logic [9:0]           dec;          // decoded selections
  logic                 io_standby;   // io configured as standby

  // capture once, never again until the next power-on reset
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_cnt  <= 32'h00000000;
      strap_done <= 1'b0;
      strap_q    <= 3'h0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 32'h00000001;
      if (strap_cnt == P_STRAP_CYC - 1) begin
        strap_done <= 1'b1;
        strap_q    <= strap_pin;
      end
    end
  end

  assign dec        = ssr_decode(strap_q);
  assign io_standby = dec[9];

  // ---------------------------------------------------------------
  // mode state machine
  // ---------------------------------------------------------------
  ssr_pkg::ssr_mode_t   mode;         // current mode
  ssr_pkg::ssr_mode_t   next_mode;    // decided mode
  logic                 normal;       // shorthand
  logic                 power_down;   // sequence shutdown

  // straps must be known before any supply other than keep-alive is sequenced up
  always_comb begin
    next_mode = mode;
    case (mode)
      ssr_pkg::MODE_SLEEP: begin
        if (strap_done && (ign || hold)) next_mode = ssr_pkg::MODE_NORMAL;
      end
      ssr_pkg::MODE_NORMAL: begin
        if (!ign && !hold) next_mode = ssr_pkg::MODE_SLEEP;
      end
      default: next_mode = ssr_pkg::MODE_SLEEP;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) mode <= ssr_pkg::MODE_SLEEP;
    else           mode <= next_mode;
  end

  assign normal     = (mode == ssr_pkg::MODE_NORMAL);
  assign power_down = !normal || input_undervoltage_lockout;

  // ---------------------------------------------------------------
  // regulator enables and pull-downs
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_core_supply_en      <= 1'b0;
      o_io_supply_en        <= 1'b0;
      o_main_supply_en      <= 1'b0;
      o_keepalive_supply_en <= 1'b1;
      o_core_pulldown       <= 1'b1;
      o_io_pulldown         <= 1'b1;
    end else begin
      o_core_supply_en      <= !power_down;
      o_main_supply_en      <= !power_down;
      // io standby stays on in sleep
      o_io_supply_en        <= !power_down || (strap_done && io_standby);
      o_keepalive_supply_en <= 1'b1;
      o_core_pulldown       <= power_down;
      o_io_pulldown         <= power_down && !(strap_done && io_standby);
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic [2:0]           delay_code;   // release delay select
  logic [31:0]          delay_cyc;    // release delay in cycles
  logic                 bus_req;      // read or write pending
  logic                 bus_go;       // transfer completes this edge

  assign bus_req   = i_avs_read || i_avs_write;
  assign bus_go    = bus_req && !o_avs_waitrequest;
  // step times code covers 0..56 ms
  assign delay_cyc = 32'({29'h00000000, delay_code} * P_STEP_CYC);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) delay_code <= ssr_pkg::CTRL_RESET;
    else if (bus_go && i_avs_write && i_avs_address == ssr_pkg::ADDR_CTRL && i_avs_byteenable[0])
      delay_code <= i_avs_writedata[2:0];
  end

  // ---------------------------------------------------------------
  // reset monitors
  // ---------------------------------------------------------------
  logic [15:0]          filt_cnt [4]; // fault persistence
  logic [31:0]          rel_cnt  [4]; // in-window persistence
  logic [3:0]           asserted;     // monitor holds its reset

  // monitors run in normal only; sleep parks them asserted so that
  // wake-up still honours the release delay
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      asserted <= 4'hF;
      for (int k = 0; k < 4; k++) begin
        filt_cnt[k] <= 16'h0000;
        rel_cnt[k]  <= 32'h00000000;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (!normal) begin
          asserted[k] <= 1'b1;
          filt_cnt[k] <= 16'h0000;
          rel_cnt[k]  <= 32'h00000000;
        end else if (flt[k]) begin
          rel_cnt[k] <= 32'h00000000;
          if (!asserted[k]) begin
            if (filt_cnt[k] == 16'(ssr_pkg::FILTER_CYC - 1)) begin
              asserted[k] <= 1'b1;
              filt_cnt[k] <= 16'h0000;
            end else begin
              filt_cnt[k] <= filt_cnt[k] + 16'h0001;
            end
          end
        end else begin
          filt_cnt[k] <= 16'h0000;
          if (asserted[k]) begin
            if (rel_cnt[k] >= delay_cyc) begin
              asserted[k] <= 1'b0;
              rel_cnt[k]  <= 32'h00000000;
            end else begin
              rel_cnt[k] <= rel_cnt[k] + 32'h00000001;
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // open-drain drivers
  // ---------------------------------------------------------------
  logic [3:0]           pin_oe;       // pull low when set
  logic [3:0]           pin_drv;      // drive value, always low

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_oe  <= 4'h0;
      pin_drv <= 4'h0;
    end else begin
      pin_oe  <= normal ? asserted : 4'h0;
      pin_drv <= 4'h0;
    end
  end

  assign o_core_supply_reset_oe = pin_oe[ssr_pkg::MON_CORE];
  assign o_io_supply_reset_oe   = pin_oe[ssr_pkg::MON_IO];
  assign o_main_supply_reset_oe = pin_oe[ssr_pkg::MON_MAIN];
  assign o_keepalive_reset_oe   = pin_oe[ssr_pkg::MON_KAM];
  assign o_core_supply_reset_n  = pin_drv[ssr_pkg::MON_CORE];
  assign o_io_supply_reset_n    = pin_drv[ssr_pkg::MON_IO];
  assign o_main_supply_reset_n  = pin_drv[ssr_pkg::MON_MAIN];
  assign o_keepalive_reset_n    = pin_drv[ssr_pkg::MON_KAM];

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  // one wait state: waitrequest falls the edge after a request arrives
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h00000000;
    end else begin
      o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
      if (bus_req && o_avs_waitrequest && i_avs_read) begin
        if (i_avs_address == ssr_pkg::ADDR_CTRL)
          o_avs_readdata <= {29'h00000000, delay_code};
        else if (i_avs_address == ssr_pkg::ADDR_STATUS)
          o_avs_readdata <= {16'h0000, io_standby, power_down, strap_done, strap_q,
                             mode, pin_lvl, asserted};
        else if (i_avs_address == ssr_pkg::ADDR_VSEL)
          o_avs_readdata <= {23'h000000, dec[8:0]};
        else
          o_avs_readdata <= 32'h00000000; // unmapped reads zero
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking ck @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  AST_NEVER_DRIVE_HIGH: assert property (pin_drv == 4'h0)
    else $error("reset pin driven high");
  AST_CORE_FILTER: assert property ($rose(asserted[0]) && $past(normal) |-> $past(flt[0]))
    else $error("core reset without core fault");
  AST_IO_FILTER: assert property ($rose(asserted[1]) && $past(normal) |-> $past(flt[1]))
    else $error("io reset without io fault");
  AST_MAIN_PIN: assert property (normal && $past(normal) && asserted[2] |=> pin_oe[2])
    else $error("main reset not pulled");
  AST_KAM_PIN: assert property (normal && asserted[3] && $past(asserted[3]) |=> pin_oe[3])
    else $error("keep-alive reset not pulled");
  AST_GLITCH: assert property ($rose(asserted[0]) && $past(normal)
                               |-> $past(filt_cnt[0]) == 16'(ssr_pkg::FILTER_CYC - 1))
    else $error("core reset before filter time");
  AST_RELEASE: assert property ($fell(asserted[1]) |-> $past(rel_cnt[1]) >= $past(delay_cyc))
    else $error("io reset released early");
  AST_SLEEP_ENTRY: assert property (normal && !ign && !hold |=> mode == ssr_pkg::MODE_SLEEP)
    else $error("sleep not entered");
  AST_SLEEP_FLOAT: assert property (!normal |=> pin_oe == 4'h0)
    else $error("reset pulled in sleep");
  AST_IO_STANDBY: assert property (strap_done && io_standby |=> o_io_supply_en && !o_io_pulldown)
    else $error("io standby switched off");
  AST_STRAP_HOLD: assert property (strap_done |=> $stable(strap_q))
    else $error("straps changed after capture");
  AST_WAKE: assert property (strap_done && !normal && (ign || hold) |=> normal)
    else $error("normal not entered");
  // core and main regulator enables follow the mode and the lockout one edge late; keep-alive stays on
  AST_KAM_ON: assert property (o_keepalive_supply_en)
    else $error("keep-alive regulator off");
  AST_SLEEP_OFF: assert property (!normal |=> !o_core_supply_en && !o_main_supply_en)
    else $error("normal regulator on in sleep");
  AST_RUN_ON: assert property (normal && !input_undervoltage_lockout |=> o_core_supply_en && o_main_supply_en && o_io_supply_en)
    else $error("regulator off in normal");
  AST_LOCKOUT: assert property (input_undervoltage_lockout |=> !o_main_supply_en && o_core_pulldown)
    else $error("lockout did not power down");
endmodule : ssr_supervisor
